// [core/wdog_pkg.sv]
package wdog_pkg;

   // Clock rate and register map.
   localparam int         CLK_HZ         = 20_000_000;
   localparam logic [7:0] CONFIG_ADDR    = 8'h9C;
   localparam logic [7:0] FAULT_ONE_ADDR = 8'hF0;
   localparam logic [7:0] FAULT_TWO_ADDR = 8'hF1;
   localparam logic [7:0] CONFIG_RESET   = 8'h00;
   localparam int         PULSE_LSB      = 3;
   localparam int         TIMEOUT_LSB    = 0;
   localparam int         MACROCELLS     = 9;
   localparam int         CNT_W          = 32;

   // Times in their own units, and the cycle counts derived from them.
   localparam int TIMEOUT_BASE_MS   = 200;
   localparam int PULSE_10_US       = 10;
   localparam int PULSE_100_US      = 100;
   localparam int PULSE_1000_US     = 1000;
   localparam int PULSE_10000_US    = 10000;
   localparam int TIMEOUT_BASE_CYC  = TIMEOUT_BASE_MS * (CLK_HZ / 1000);
   localparam int PULSE_10_CYC      = PULSE_10_US * (CLK_HZ / 1_000_000);
   localparam int PULSE_100_CYC     = PULSE_100_US * (CLK_HZ / 1_000_000);
   localparam int PULSE_1000_CYC    = PULSE_1000_US * (CLK_HZ / 1_000_000);
   localparam int PULSE_10000_CYC   = PULSE_10000_US * (CLK_HZ / 1_000_000);

   // Layout of the configuration register.
   typedef struct packed {
      logic [2:0] unused_bits;
      logic [1:0] pulse_width_select;
      logic [2:0] timeout_select;
   } wd_config_s;

   // One register access as delivered by the serial management port.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_s;

   typedef enum logic {CLEAR_IDLE, CLEAR_ARMED} clear_state_e;

endpackage

// [core/pulse_stretch.sv]
`timescale 1ns/1ps
module pulse_stretch #(
   parameter int CNT_W = 32
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] length,
   output logic                  active
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] run_r;
   logic [CNT_W-1:0] want_r;

   // A new start restarts the pulse, so a retrigger stretches it rather than splitting it.
   always_ff @(posedge clock) begin
      if (srst) begin
         count_r <= '0;
         active  <= 1'b0;
      end else if (start) begin
         count_r <= length;
         active  <= 1'b1;
      end else if (count_r > 1) begin
         count_r <= count_r - 1'b1;
      end else begin
         count_r <= '0;
         active  <= 1'b0;
      end
   end

   // Helper that measures each pulse for the width check.
   always_ff @(posedge clock) begin
      if (srst) begin
         run_r  <= '0;
         want_r <= '0;
      end else if (start) begin
         run_r  <= '0;
         want_r <= length;
      end else if (active) begin
         run_r  <= run_r + 1'b1;
      end
   end

   a_pulse_starts: assert property (@(posedge clock) disable iff (srst)
      start |=> active) else $error("Pulse did not start.");

   a_pulse_width: assert property (@(posedge clock) disable iff (srst)
      $fell(active) |-> run_r == want_r) else $error("Pulse width wrong.");

endmodule // pulse_stretch

// [core/watchdog_fault_detector.sv]
`timescale 1ns/1ps
// Behaviour
// - Either edge on the input proves life.
// - Timeout sets fault level, held until cleared.
// - Timeout also emits one positive pulse.
// - Width field picks 10/100/1000/10000 us.
// - Period field: off, or 200 ms doubling.
// - Fault clears after reading latch one, two.
// - Both signals reach nine macrocells, invertible.
module watchdog_fault_detector
   import wdog_pkg::*;
#(
   parameter int TIMEOUT_BASE  = TIMEOUT_BASE_CYC,
   parameter int PULSE_1000_C  = PULSE_1000_CYC,
   parameter int PULSE_10000_C = PULSE_10000_CYC
) (
   input  wire logic                       CLOCK,
   input  wire logic                       SRST,
   input  wire logic                       WATCHDOG_INPUT,
   input  wire wdog_pkg::reg_req_s         REG_REQ,
   output logic [7:0]                      REG_RDATA,
   output logic                            REG_HIT,
   input  wire logic [MACROCELLS-1:0]      FAULT_INVERT,
   input  wire logic [MACROCELLS-1:0]      PULSE_INVERT,
   output logic                            WD_FAULT,
   output logic                            WD_PULSE,
   output logic [MACROCELLS-1:0]           MACROCELL_FAULT,
   output logic [MACROCELLS-1:0]           MACROCELL_PULSE
);
   import wdog_pkg::*;

   wd_config_s       cfg_r;
   logic             sync1_r;
   logic             sync2_r;
   logic             prev_r;
   logic [CNT_W-1:0] count_r;
   logic             fault_r;
   clear_state_e     clear_r;
   logic [7:0]       rdata_r;
   logic             hit_r;

   wire              edge_seen;
   wire              enabled;
   wire [CNT_W-1:0]  period_w;
   wire              timeout;
   wire              cfg_wr;
   wire              cfg_rd;
   wire              rd_one;
   wire              rd_two;
   wire              fault_clear;
   logic [CNT_W-1:0] pulse_len;

   // Register decode; the fault latch reads only come through here as strobes.
   assign cfg_wr = REG_REQ.wr && (REG_REQ.addr == CONFIG_ADDR);
   assign cfg_rd = REG_REQ.rd && (REG_REQ.addr == CONFIG_ADDR);
   assign rd_one = REG_REQ.rd && (REG_REQ.addr == FAULT_ONE_ADDR);
   assign rd_two = REG_REQ.rd && (REG_REQ.addr == FAULT_TWO_ADDR);

   // All eight bits are stored, the unused ones included, since they read back as written.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         cfg_r <= CONFIG_RESET;
      end else if (cfg_wr) begin
         cfg_r <= REG_REQ.wdata;
      end
   end

   // Read data is registered; unmapped addresses answer zero with no hit.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         rdata_r <= 8'h00;
         hit_r   <= 1'b0;
      end else begin
         rdata_r <= cfg_rd ? cfg_r : 8'h00;
         hit_r   <= cfg_rd | cfg_wr;
      end
   end

   assign REG_RDATA = rdata_r;
   assign REG_HIT   = hit_r;

   // The pin is asynchronous, so two flops come before the edge detector.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= WATCHDOG_INPUT;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign edge_seen = sync2_r ^ prev_r;

   // Period doubles with each code step above one; code zero stops the watchdog.
   assign enabled  = cfg_r.timeout_select != 3'h0;
   assign period_w = CNT_W'(TIMEOUT_BASE) << (cfg_r.timeout_select - 3'h1);
   // An edge that lands in the last cycle of the period still counts as a kick.
   assign timeout  = enabled && !edge_seen && (count_r == period_w - 1'b1);

   // A configuration write also restarts the count, so a new period starts cleanly.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         count_r <= '0;
      end else if (!enabled || edge_seen || cfg_wr || timeout) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   // Clear needs latch one then latch two; a timeout in the same cycle wins.
   assign fault_clear = rd_two && (clear_r == CLEAR_ARMED);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         fault_r <= 1'b0;
         clear_r <= CLEAR_IDLE;
      end else begin
         if (timeout) begin
            fault_r <= 1'b1;
         end else if (fault_clear) begin
            fault_r <= 1'b0;
         end
         case (clear_r)
            CLEAR_IDLE:  clear_r <= rd_one ? CLEAR_ARMED : CLEAR_IDLE;
            CLEAR_ARMED: clear_r <= rd_two ? CLEAR_IDLE : CLEAR_ARMED;
            default:     clear_r <= CLEAR_IDLE;
         endcase
      end
   end

   // Width is sampled when the pulse starts.
   always_comb begin
      case (cfg_r.pulse_width_select)
         2'h0:    pulse_len = CNT_W'(PULSE_10_CYC);
         2'h1:    pulse_len = CNT_W'(PULSE_100_CYC);
         2'h2:    pulse_len = CNT_W'(PULSE_1000_C);
         default: pulse_len = CNT_W'(PULSE_10000_C);
      endcase
   end

   pulse_stretch #(
      .CNT_W (CNT_W)
   ) pulse_stretch_i (
      .clock  (CLOCK),
      .srst   (SRST),
      .start  (timeout),
      .length (pulse_len),
      .active (WD_PULSE)
   );

   assign WD_FAULT = fault_r;

   // Each macrocell gets its own registered, optionally inverted copy of both signals.
   genvar i;
   generate
      for (i = 0; i < MACROCELLS; i++) begin : g_cell
         always_ff @(posedge CLOCK) begin
            if (SRST) begin
               MACROCELL_FAULT[i] <= 1'b0;
               MACROCELL_PULSE[i] <= 1'b0;
            end else begin
               MACROCELL_FAULT[i] <= fault_r ^ FAULT_INVERT[i];
               MACROCELL_PULSE[i] <= WD_PULSE ^ PULSE_INVERT[i];
            end
         end

         a_cell_invert: assert property (@(posedge CLOCK) disable iff (SRST)
            ##1 MACROCELL_FAULT[i] == ($past(fault_r) ^ $past(FAULT_INVERT[i])))
            else $error("Macrocell fault copy wrong.");

         a_cell_pulse: assert property (@(posedge CLOCK) disable iff (SRST)
            ##1 MACROCELL_PULSE[i] == ($past(WD_PULSE) ^ $past(PULSE_INVERT[i])))
            else $error("Macrocell pulse copy wrong.");
      end
   endgenerate

   a_edge_restarts: assert property (@(posedge CLOCK) disable iff (SRST)
      edge_seen |=> count_r == '0) else $error("Edge did not restart count.");

   a_timeout_fault: assert property (@(posedge CLOCK) disable iff (SRST)
      timeout |=> fault_r && WD_PULSE) else $error("Timeout not flagged.");

   a_fault_holds: assert property (@(posedge CLOCK) disable iff (SRST)
      fault_r && !fault_clear |=> fault_r) else $error("Fault dropped early.");

   a_clear_order: assert property (@(posedge CLOCK) disable iff (SRST)
      $fell(fault_r) |-> $past(rd_two) && $past(clear_r) == CLEAR_ARMED)
      else $error("Fault cleared out of order.");

   a_disabled_quiet: assert property (@(posedge CLOCK) disable iff (SRST)
      !enabled |-> !timeout ##1 count_r == '0) else $error("Disabled watchdog counted.");

   a_config_read: assert property (@(posedge CLOCK) disable iff (SRST)
      cfg_rd |=> REG_RDATA == $past(cfg_r)) else $error("Config readback wrong.");

   // A write lands in the register and answers with a hit one cycle later.
   a_config_write: assert property (@(posedge CLOCK) disable iff (SRST)
      cfg_wr |=> cfg_r == $past(REG_REQ.wdata) && REG_HIT) else $error("Config write lost.");

   // The count never passes the selected period while the watchdog runs.
   a_count_bounded: assert property (@(posedge CLOCK) disable iff (SRST)
      enabled |-> count_r < period_w) else $error("Count ran past the period.");

   // A timeout is never declared in a cycle that saw a kick.
   a_kick_wins: assert property (@(posedge CLOCK) disable iff (SRST)
      edge_seen |-> !timeout) else $error("Timeout despite an edge.");

   // Fault and pulse rise only as a result of a timeout.
   a_fault_cause: assert property (@(posedge CLOCK) disable iff (SRST)
      $rose(fault_r) |-> $past(timeout)) else $error("Fault set without timeout.");

   a_pulse_cause: assert property (@(posedge CLOCK) disable iff (SRST)
      $rose(WD_PULSE) |-> $past(timeout)) else $error("Pulse without timeout.");

   // Reading latch one arms the clear, whatever state the sequence was in.
   a_clear_arms: assert property (@(posedge CLOCK) disable iff (SRST)
      rd_one |=> clear_r == CLEAR_ARMED) else $error("Latch one read did not arm.");

endmodule // watchdog_fault_detector

// [sim/proc_clock_model.sv]
`timescale 1ns/1ps
// Processor whose clock toggles the watchdog pin every half cycles while it runs.
module proc_clock_model (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        run,
   input  wire logic [15:0] half,
   output logic             watchdog_input
);
   logic [15:0] cnt_r;
   wire         wrap = (cnt_r + 16'h0001 >= half);
   // A stalled core parks the pin at its last level, so no edge reaches the detector.
   always_ff @(posedge clock) begin
      cnt_r <= (srst || !run || wrap) ? 16'h0000 : cnt_r + 16'h0001;
      watchdog_input   <= srst ? 1'b0 : watchdog_input ^ (run && wrap);
   end
endmodule // proc_clock_model

// [sim/watchdog_fault_detector_tb.sv]
`timescale 1ns/1ps
module watchdog_fault_detector_tb;
   import wdog_pkg::*;
   localparam int         BASE   = 50;
   localparam int         P1000  = 30;
   localparam int         P10000 = 40;
   logic                  clock, srst, watchdog_input, run, wd_fault, wd_pulse, reg_hit;
   logic                  mc_ok = 1'b0;
   logic [15:0]           half;
   reg_req_s              req;
   logic [7:0]            rdata, cfg;
   logic [MACROCELLS-1:0] finv, pinv, mc_fault, mc_pulse, mf_exp, mp_exp;
   logic [31:0]           seed = 32'h0000D413, g, w;
   logic [31:0]           widths[4] = '{PULSE_10_CYC, PULSE_100_CYC, P1000, P10000};
   logic [7:0]            exp_q[$];
   int                    fail_count = 0, check_count = 0;

   watchdog_fault_detector #(.TIMEOUT_BASE(BASE), .PULSE_1000_C(P1000),
      .PULSE_10000_C(P10000))
      watchdog_fault_detector_i (.CLOCK(clock), .SRST(srst), .WATCHDOG_INPUT(watchdog_input),
      .REG_REQ(req), .REG_RDATA(rdata), .REG_HIT(reg_hit), .FAULT_INVERT(finv),
      .PULSE_INVERT(pinv), .WD_FAULT(wd_fault), .WD_PULSE(wd_pulse),
      .MACROCELL_FAULT(mc_fault), .MACROCELL_PULSE(mc_pulse));
   proc_clock_model proc_clock_model_i (.clock(clock), .srst(srst), .run(run), .half(half),
      .watchdog_input(watchdog_input));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One access; the idle cycle after it keeps back-to-back calls from racing on req.
   task automatic acc(input logic [7:0] a, input logic wr, input logic rd, input logic [7:0] d);
      logic hit;
      hit = (a == CONFIG_ADDR);
      if (wr) cfg = d;
      if (hit) exp_q.push_back((rd && !wr) ? cfg : 8'h00);
      req = '{addr: a, wr: wr, rd: rd, wdata: d};
      tick(1);
      chk(reg_hit, hit);
      req = '0;
      tick(1);
   endtask
   task automatic wr_cfg(input logic [7:0] v);
      acc(CONFIG_ADDR, 1'b1, 1'b0, v);
      acc(CONFIG_ADDR, 1'b0, 1'b1, 8'h00);
      finv = MACROCELLS'(rnd());
      pinv = MACROCELLS'(rnd());
   endtask
   // Time from the call to the next rise, then the high time of that pulse.
   task automatic measure(output logic [31:0] gap, output logic [31:0] width);
      gap = 0;
      width = 0;
      while (wd_pulse !== 1'b1 && gap < 8000) begin
         tick(1);
         gap++;
      end
      while (wd_pulse === 1'b1 && width < 8000) begin
         tick(1);
         width++;
      end
      chk(gap < 8000, 1'b1);
   endtask

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Watcher: read data against the oldest note, macrocells against the last cycle.
   always @(posedge clock) begin
      if (reg_hit === 1'b1) begin
         chk(exp_q.size() != 0, 1'b1);
         if (exp_q.size() != 0) chk(rdata, exp_q.pop_front());
      end
      if (mc_ok) begin
         chk(mc_fault, mf_exp);
         chk(mc_pulse, mp_exp);
      end
      mf_exp = {MACROCELLS{wd_fault}} ^ finv;
      mp_exp = {MACROCELLS{wd_pulse}} ^ pinv;
      mc_ok = (srst === 1'b0);
   end
   // A hang adds a failure, then ends the run through end_sim as the tests do.
   initial begin
      #3_000_000;
      fail_count++;
      end_sim();
   end
   initial begin
      srst = 1'b1;
      run = 1'b0;
      half = 16'h0028;
      req = '0;
      finv = '0;
      pinv = '0;
      cfg = CONFIG_RESET;
      repeat (6) @(posedge clock);
      #1 srst = 1'b0;
      acc(CONFIG_ADDR, 1'b0, 1'b1, 8'h00);
      acc(8'h9D, 1'b0, 1'b1, 8'h00);
      $display("test registers done");
      wr_cfg(8'hA1);
      run = 1'b1;
      tick(1000);
      chk(wd_fault, 1'b0);
      half = 16'h003C;
      tick(400);
      chk(wd_fault, 1'b1);
      run = 1'b0;
      $display("test kicks done");
      wr_cfg(8'h00);
      acc(FAULT_TWO_ADDR, 1'b0, 1'b1, 8'h00);
      acc(FAULT_ONE_ADDR, 1'b0, 1'b1, 8'h00);
      chk(wd_fault, 1'b1);
      acc(FAULT_TWO_ADDR, 1'b0, 1'b1, 8'h00);
      chk(wd_fault, 1'b0);
      tick(400);
      chk({wd_fault, wd_pulse}, 2'b00);
      $display("test clear and disable done");
      for (int k = 1; k < 8; k++) begin
         wr_cfg(8'(rnd() & 32'h000000E0) | 8'h10 | k[7:0]);
         measure(g, w);
         measure(g, w);
         chk(g + w, BASE << (k - 1));
         chk(w, widths[2]);
      end
      $display("test periods done");
      for (int p = 0; p < 4; p++) begin
         wr_cfg({3'b000, p[1:0], 3'b111});
         measure(g, w);
         chk(w, widths[p]);
         chk(wd_fault, 1'b1);
      end
      $display("test pulse widths done");
      end_sim();
   end
endmodule // watchdog_fault_detector_tb
